// [pkg/clock_gate_regs.svh]
`ifndef CLOCK_GATE_REGS_SVH
`define CLOCK_GATE_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_IDLE_CONFIG        16'h0001
`define IDX_IDLE_STATUS        16'h0002
`define IDX_INT_FLAG           16'h0003
`define IDX_INT_ENABLE         16'h0004
`define IDX_PERIPH_GATE_ONE    16'h1C02
`define IDX_PERIPH_GATE_TWO    16'h1C03

// Idle configuration / status field positions
`define BIT_CPU                0
`define BIT_DATA_PORT          5
`define BIT_IO_PORT            6
`define BIT_MEM_PORT           7
`define BIT_INSTR_PORT         8
`define BIT_FFT                9
`define CFG_FIELD_LSB          1
`define CFG_FIELD_MSB          4
`define CFG_FIELD_VALID        4'h7
`define IDLE_BITS_MASK         16'h03E1
`define WAKE_CLEAR_MASK        16'h0161

// Reset values
`define IDLE_CONFIG_RESET      16'h000E
`define IDLE_STATUS_RESET      16'h0000
`define PERIPH_GATE_RESET      16'h0000

// First gating register
`define BIT_SYSTEM_CLOCK_DISABLE     15
`define BIT_GATE_RESERVED      5

// Interrupt flag register: bit 0 is the bus error flag
`define BIT_BUS_ERROR          0

// Interrupt visible this many running CPU cycles after wake
`define IRQ_FLAG_DELAY         3
// Cycles from gate register write to gate outputs
`define GATE_LATENCY_MAX       6

`endif

// [pkg/clock_gate_pkg.sv]
package clock_gate_pkg;

    typedef enum logic [2:0] {
        sel_none,
        sel_idle_config,
        sel_idle_status,
        sel_int_flag,
        sel_int_enable,
        sel_gate_one,
        sel_gate_two
    } reg_sel_t;

    typedef enum logic [1:0] {
        cmd_idle,
        cmd_apply,
        cmd_reject
    } idle_cmd_t;

endpackage

// [rtl/idle_and_peripheral_clock_gating.sv]
`timescale 1ns/100ps

`include "clock_gate_regs.svh"

module idle_and_peripheral_clock_gating
    import clock_gate_pkg::*;
#(
    parameter int IRQ_COUNT = 8
)(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 idle_exec,
    input  wire logic [IRQ_COUNT-1:0] irq_in,
    input  wire logic                 wake_pin,
    output logic                      cpu_clk_en,
    output logic                      data_port_clk_en,
    output logic                      io_port_clk_en,
    output logic                      mem_port_clk_en,
    output logic                      instr_port_clk_en,
    output logic                      fft_clk_en,
    output logic                      system_clock_en,
    output logic      [15:0]          periph_one_clk_en,
    output logic      [15:0]          periph_two_clk_en
);

    if (IRQ_COUNT < 1 || IRQ_COUNT > 31) begin : g_bad_irq_count
        $error("IRQ_COUNT must lie between 1 and 31");
    end
    if (`IRQ_FLAG_DELAY < 1) begin : g_bad_flag_delay
        $error("Interrupt flag delay must be at least one cycle");
    end

    function automatic reg_sel_t decode(input logic [31:0] addr);
        reg_sel_t sel;
        sel = sel_none;
        if (addr[1:0] == 2'h0) begin
            case (addr[31:2])
                30'(`IDX_IDLE_CONFIG):     sel = sel_idle_config;
                30'(`IDX_IDLE_STATUS):     sel = sel_idle_status;
                30'(`IDX_INT_FLAG):        sel = sel_int_flag;
                30'(`IDX_INT_ENABLE):      sel = sel_int_enable;
                30'(`IDX_PERIPH_GATE_ONE): sel = sel_gate_one;
                30'(`IDX_PERIPH_GATE_TWO): sel = sel_gate_two;
                default:                   sel = sel_none;
            endcase
        end
        return sel;
    endfunction

    logic [15:0]          idle_config_reg;
    logic [15:0]          idle_status_reg;
    logic [31:0]          interrupt_flag_reg;
    logic [IRQ_COUNT-1:0] irq_enable;
    logic [15:0]          peripheral_clock_gate_one;
    logic [15:0]          peripheral_clock_gate_two;
    logic [IRQ_COUNT-1:0] irq_meta;
    logic [IRQ_COUNT-1:0] irq_sync;
    logic [IRQ_COUNT-1:0] irq_held;
    logic                 wake_meta;
    logic                 wake_sync;
    logic [15:0]          gate_one_stage;
    logic [15:0]          gate_two_stage;
    logic                 sys_stage;
    logic [15:0]          status_stage;
    logic [IRQ_COUNT-1:0] irq_delay [`IRQ_FLAG_DELAY];
    reg_sel_t             access_sel;
    reg_sel_t             setup_sel;
    logic                 wr_strobe;
    logic                 irq_wake;
    logic                 cpu_running;
    logic                 cfg_invalid;
    idle_cmd_t            idle_cmd;
    logic [15:0]          next_idle_status;
    logic [31:0]          next_flags;
    logic [31:0]          flag_set;

    // Register write select, shared by every writable register
    function automatic logic write_hit(input reg_sel_t sel);
        return wr_strobe && (access_sel == sel);
    endfunction

    // Flag bits above the last interrupt line always read zero
    function automatic logic [31:0] flag_mask();
        logic [63:0] ones;
        ones = (64'h1 << (IRQ_COUNT + 1)) - 64'h1;
        return ones[31:0];
    endfunction

    // Zero-wait slave; read data is latched in the setup cycle
    assign access_sel = decode(paddr);
    assign setup_sel  = access_sel;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && (access_sel == sel_none);
    assign wr_strobe  = psel && penable && pwrite && (access_sel != sel_none);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (setup_sel)
                sel_idle_config: prdata <= {16'h0000, idle_config_reg};
                sel_idle_status: prdata <= {16'h0000, idle_status_reg};
                sel_int_flag:    prdata <= interrupt_flag_reg;
                sel_int_enable:  prdata <= 32'(irq_enable);
                sel_gate_one:    prdata <= {16'h0000, peripheral_clock_gate_one};
                sel_gate_two:    prdata <= {16'h0000, peripheral_clock_gate_two};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Pin and interrupt inputs: first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_meta  <= '0;
            irq_sync  <= '0;
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            irq_meta  <= irq_in;
            irq_sync  <= irq_meta;
            wake_meta <= wake_pin;
            wake_sync <= wake_meta;
        end
    end

    assign irq_wake = |(irq_sync & irq_enable);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_config_reg <= `IDLE_CONFIG_RESET;
        end else if (write_hit(sel_idle_config)) begin
            // Storing a new config changes no clock by itself
            idle_config_reg <= pwdata[15:0] & 16'(`IDLE_BITS_MASK | 16'h001E);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= '0;
        end else if (write_hit(sel_int_enable)) begin
            irq_enable <= pwdata[IRQ_COUNT-1:0];
        end
    end

    // Port idle needs the valid field; CPU-side ports need CPU idle too
    always_comb begin
        cfg_invalid = 1'b0;
        if ((idle_config_reg[`BIT_DATA_PORT] || idle_config_reg[`BIT_IO_PORT] ||
             idle_config_reg[`BIT_INSTR_PORT] || idle_config_reg[`BIT_MEM_PORT]) &&
            idle_config_reg[`CFG_FIELD_MSB:`CFG_FIELD_LSB] != `CFG_FIELD_VALID) begin
            cfg_invalid = 1'b1;
        end
        if ((idle_config_reg[`BIT_DATA_PORT] || idle_config_reg[`BIT_IO_PORT] ||
             idle_config_reg[`BIT_INSTR_PORT]) && !idle_config_reg[`BIT_CPU]) begin
            cfg_invalid = 1'b1;
        end
    end

    // Idle strobe comes only from running, single-issue CPU
    always_comb begin
        idle_cmd = cmd_idle;
        if (idle_exec && cpu_running) begin
            idle_cmd = cfg_invalid ? cmd_reject : cmd_apply;
        end
    end

    always_comb begin
        next_idle_status = idle_status_reg;
        case (idle_cmd)
            cmd_apply:  next_idle_status = idle_config_reg & `IDLE_BITS_MASK;
            cmd_reject: next_idle_status = idle_status_reg;
            default:    next_idle_status = idle_status_reg;
        endcase
        if (irq_wake) begin
            // Accelerator and memory port stay idle until software reapplies
            next_idle_status = next_idle_status & ~16'(`WAKE_CLEAR_MASK);
        end
    end

    // Status is read-only to the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_status_reg <= `IDLE_STATUS_RESET;
        end else begin
            idle_status_reg <= next_idle_status;
        end
    end

    // Lines seen while the core is halted are kept, so a short pulse still flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_held <= '0;
        end else if (cpu_running) begin
            irq_held <= '0;
        end else begin
            irq_held <= irq_held | (irq_sync & irq_enable);
        end
    end

    // Interrupt becomes visible after three running CPU cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `IRQ_FLAG_DELAY; i++) begin
                irq_delay[i] <= '0;
            end
        end else if (cpu_running) begin
            irq_delay[0] <= (irq_sync & irq_enable) | irq_held;
            for (int i = 1; i < `IRQ_FLAG_DELAY; i++) begin
                irq_delay[i] <= irq_delay[i-1];
            end
        end
    end

    always_comb begin
        flag_set = 32'h0000_0000;
        flag_set[`BIT_BUS_ERROR] = (idle_cmd == cmd_reject);
        flag_set[IRQ_COUNT:1] = cpu_running ? irq_delay[`IRQ_FLAG_DELAY-1] : '0;
    end

    // Write one to clear; a new event in the same cycle wins
    always_comb begin
        next_flags = interrupt_flag_reg;
        if (write_hit(sel_int_flag)) begin
            next_flags = next_flags & ~pwdata;
        end
        next_flags = next_flags | flag_set;
        next_flags = next_flags & flag_mask();
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_flag_reg <= 32'h0000_0000;
        end else begin
            interrupt_flag_reg <= next_flags;
        end
    end

    // Bit 15 holds only while the wake pin is low; wake clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_clock_gate_one <= `PERIPH_GATE_RESET;
        end else begin
            if (write_hit(sel_gate_one)) begin
                peripheral_clock_gate_one <= pwdata[15:0];
            end
            if (wake_sync) begin
                peripheral_clock_gate_one[`BIT_SYSTEM_CLOCK_DISABLE] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_clock_gate_two <= `PERIPH_GATE_RESET;
        end else if (write_hit(sel_gate_two)) begin
            peripheral_clock_gate_two <= pwdata[15:0];
        end
    end

    // Registered enables feed latch-based gate cells, so no runt pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_one_stage <= `PERIPH_GATE_RESET;
            gate_two_stage <= `PERIPH_GATE_RESET;
            sys_stage      <= 1'b0;
            status_stage   <= `IDLE_STATUS_RESET;
        end else begin
            gate_one_stage <= peripheral_clock_gate_one;
            gate_two_stage <= peripheral_clock_gate_two;
            sys_stage      <= peripheral_clock_gate_one[`BIT_SYSTEM_CLOCK_DISABLE] && !wake_sync;
            status_stage   <= next_idle_status;
        end
    end

    assign cpu_running = !status_stage[`BIT_CPU] && !sys_stage;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_clock_en   <= 1'b1;
            periph_one_clk_en <= 16'hFFFF;
            periph_two_clk_en <= 16'hFFFF;
        end else begin
            system_clock_en   <= !sys_stage;
            // Gated peripherals hold state while stopped
            periph_one_clk_en <= ~gate_one_stage | 16'h8020;
            periph_two_clk_en <= ~gate_two_stage;
        end
    end

    // CPU domain gates also follow the system clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en        <= 1'b1;
            data_port_clk_en  <= 1'b1;
            io_port_clk_en    <= 1'b1;
            mem_port_clk_en   <= 1'b1;
            instr_port_clk_en <= 1'b1;
            fft_clk_en        <= 1'b1;
        end else begin
            cpu_clk_en        <= cpu_running;
            data_port_clk_en  <= !status_stage[`BIT_DATA_PORT] && !sys_stage;
            io_port_clk_en    <= !status_stage[`BIT_IO_PORT] && !sys_stage;
            mem_port_clk_en   <= !status_stage[`BIT_MEM_PORT] && !sys_stage;
            instr_port_clk_en <= !status_stage[`BIT_INSTR_PORT] && !sys_stage;
            fft_clk_en        <= !status_stage[`BIT_FFT] && !sys_stage;
        end
    end

endmodule

// [testbench/idle_gate_properties.sv]
`timescale 1ns/100ps
`include "clock_gate_regs.svh"
module idle_gate_properties #(
    parameter int IRQ_COUNT = 8
)(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic                 pready,
    input wire logic [31:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 idle_exec,
    input wire logic [IRQ_COUNT-1:0] irq_in,
    input wire logic                 wake_pin,
    input wire logic                 cpu_clk_en,
    input wire logic                 data_port_clk_en,
    input wire logic                 io_port_clk_en,
    input wire logic                 mem_port_clk_en,
    input wire logic                 instr_port_clk_en,
    input wire logic                 fft_clk_en,
    input wire logic                 system_clock_en,
    input wire logic [15:0]          periph_one_clk_en
);
    logic [15:0]          cfg;
    logic [15:0]          g1;
    logic [IRQ_COUNT-1:0] ien;
    logic                 wr;
    logic                 bad;
    logic                 wr_one;
    logic [5:0]           dom_en;
    assign wr = psel && penable && pwrite && pready;
    assign wr_one = wr && paddr[31:2] == 30'(`IDX_PERIPH_GATE_ONE);
    assign bad = (|cfg[8:5] && cfg[4:1] != `CFG_FIELD_VALID) || (|{cfg[8], cfg[6:5]} && !cfg[0]);
    assign dom_en = {cpu_clk_en, data_port_clk_en, io_port_clk_en, instr_port_clk_en,
                     mem_port_clk_en, fft_clk_en};
    // Shadows of software writes, so each enable can be tied to its cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `IDLE_CONFIG_RESET;
            g1  <= 16'h0000;
            ien <= '0;
        end else if (wr) begin
            if (paddr[31:2] == 30'(`IDX_IDLE_CONFIG)) cfg <= {6'h00, pwdata[9:0]};
            if (wr_one) g1 <= pwdata[15:0];
            if (paddr[31:2] == 30'(`IDX_INT_ENABLE)) ien <= pwdata[IRQ_COUNT-1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_config_apply: assert property (
        idle_exec && cpu_clk_en && system_clock_en && !bad |-> ##2
        dom_en == ~{cfg[0], cfg[5], cfg[6], cfg[8], cfg[7], cfg[9]})
        else $error("idle apply gave wrong enables");
    a_cpu_stop_cause: assert property (
        $fell(cpu_clk_en) |-> $past(idle_exec, 2) || !system_clock_en)
        else $error("cpu clock stopped without cause");
    a_cpu_kept: assert property (
        idle_exec && cpu_clk_en && system_clock_en && (bad || !cfg[0]) |=> cpu_clk_en[*4])
        else $error("cpu clock stopped by idle that keeps it");
    a_irq_wake: assert property (
        (system_clock_en && !cpu_clk_en && |(irq_in & ien))[*3] |-> ##[1:4] dom_en[5:2] == 4'hF)
        else $error("interrupt did not wake cpu domain");
    a_no_irq_restart: assert property (
        $rose(mem_port_clk_en) || $rose(fft_clk_en) |->
        $past(idle_exec, 2) || !$past(system_clock_en) || !$past(system_clock_en, 2))
        else $error("memory port or accelerator restarted without idle");
    a_gate_one_follow: assert property (
        wr_one |-> ##[1:6] periph_one_clk_en == {1'b1, ~g1[14:6], 1'b1, ~g1[4:0]})
        else $error("gate one enables late or wrong");
    a_sys_stop: assert property (
        wr_one && pwdata[15] && !wake_pin && !$past(wake_pin) && !$past(wake_pin, 2)
        |-> ##[1:6] !system_clock_en ##[0:2] !cpu_clk_en)
        else $error("system clock not stopped");
    a_sys_wake: assert property (
        (!system_clock_en && wake_pin)[*3] |-> ##[1:6] system_clock_en)
        else $error("wake pin did not restart system clock");
endmodule
bind idle_and_peripheral_clock_gating idle_gate_properties #(.IRQ_COUNT(IRQ_COUNT)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .paddr(paddr), .pwdata(pwdata), .idle_exec(idle_exec),
    .irq_in(irq_in), .wake_pin(wake_pin), .cpu_clk_en(cpu_clk_en),
    .data_port_clk_en(data_port_clk_en), .io_port_clk_en(io_port_clk_en),
    .mem_port_clk_en(mem_port_clk_en), .instr_port_clk_en(instr_port_clk_en),
    .fft_clk_en(fft_clk_en), .system_clock_en(system_clock_en),
    .periph_one_clk_en(periph_one_clk_en));

// [testbench/cpu_model.sv]
`timescale 1ns/100ps
module cpu_model (
    input  wire logic       pclk,
    input  wire logic       cpu_clk_en,
    input  wire logic       system_clock_en,
    output logic            idle_exec,
    output logic      [7:0] irq_in
);
    initial begin
        idle_exec = 1'b0;
        irq_in = 8'h00;
    end
    // A halted core retires nothing, and idle always goes alone
    task automatic run_idle();
        @(posedge pclk);
        if (cpu_clk_en && system_clock_en) idle_exec <= 1'b1;
        @(posedge pclk);
        idle_exec <= 1'b0;
    endtask
    task automatic set_irq(input int n, input logic lvl);
        @(posedge pclk);
        irq_in[n] <= lvl;
    endtask
endmodule

// [testbench/test_idle_and_peripheral_clock_gating.sv]
`timescale 1ns/100ps
`include "clock_gate_regs.svh"
module test_idle_and_peripheral_clock_gating;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        idle_exec;
    logic [7:0]  irq_in;
    logic        wake_pin;
    logic [5:0]  dom_en;
    logic        system_clock_en;
    logic [15:0] periph_one_clk_en;
    logic [15:0] periph_two_clk_en;
    logic [15:0] g;
    logic [32:0] expq[$];
    logic [31:0] bad_cfg[3] = '{32'h0000_0020, 32'h0000_0081, 32'h0000_002E};
    int          mismatches;
    int          checks;
    int          cycles;
    idle_and_peripheral_clock_gating i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .idle_exec(idle_exec), .irq_in(irq_in), .wake_pin(wake_pin),
        .cpu_clk_en(dom_en[5]), .data_port_clk_en(dom_en[4]), .io_port_clk_en(dom_en[3]),
        .instr_port_clk_en(dom_en[2]), .mem_port_clk_en(dom_en[1]), .fft_clk_en(dom_en[0]),
        .system_clock_en(system_clock_en), .periph_one_clk_en(periph_one_clk_en),
        .periph_two_clk_en(periph_two_clk_en));
    cpu_model i_cpu (.pclk(pclk), .cpu_clk_en(dom_en[5]), .system_clock_en(system_clock_en),
        .idle_exec(idle_exec), .irq_in(irq_in));
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;
    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {14'h0000, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected read word is {pslverr, prdata}
    task automatic rd(input logic [15:0] idx, input logic [32:0] exp);
        expq.push_back(exp);
        apb(idx, 1'b0, 32'h0000_0000);
    endtask
    task automatic wait_cy(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (expq.size() == 0) check("unexpected read", 33'h1, 33'h0);
            else check("read word", {pslverr, prdata}, expq.pop_front());
        end
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, wake_pin} = '0;
        void'($urandom(51));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IDX_PERIPH_GATE_TWO, 33'h0_0000_0000);
        rd(`IDX_IDLE_CONFIG, 33'h0_0000_000E);
        rd(16'h0040, 33'h1_0000_0000);
        apb(`IDX_IDLE_STATUS, 1'b1, 32'h0000_03E1);
        rd(`IDX_IDLE_STATUS, 33'h0_0000_0000);
        check("gate one en", 33'(periph_one_clk_en), 33'h0_0000_FFFF);
        for (int i = 0; i < 15; i++) begin
            apb(`IDX_PERIPH_GATE_ONE, 1'b1, 32'h0020 | (32'h1 << i));
            wait_cy(6);
            check("gate one en", 33'(periph_one_clk_en),
                  {17'h00000, ~(16'h0001 << i) | 16'h0020});
            rd(`IDX_PERIPH_GATE_ONE, 33'h0020 | (33'h1 << i));
        end
        g = 16'($urandom());
        apb(`IDX_PERIPH_GATE_TWO, 1'b1, {16'h0000, g});
        wait_cy(6);
        check("gate two en", 33'(periph_two_clk_en), {17'h00000, ~g});
        rd(`IDX_PERIPH_GATE_TWO, {17'h00000, g});
        apb(`IDX_PERIPH_GATE_ONE, 1'b1, 32'h0000_0020);
        apb(`IDX_IDLE_CONFIG, 1'b1, 32'h0000_028E);
        wait_cy(3);
        check("domain en", 33'(dom_en), 33'h3F);
        i_cpu.run_idle();
        wait_cy(3);
        check("domain en", 33'(dom_en), 33'h3C);
        rd(`IDX_IDLE_STATUS, 33'h0_0000_0280);
        foreach (bad_cfg[k]) begin
            apb(`IDX_IDLE_CONFIG, 1'b1, bad_cfg[k]);
            i_cpu.run_idle();
            wait_cy(3);
            rd(`IDX_INT_FLAG, 33'h0_0000_0001);
            rd(`IDX_IDLE_STATUS, 33'h0_0000_0280);
            apb(`IDX_INT_FLAG, 1'b1, 32'h0000_0001);
        end
        apb(`IDX_INT_ENABLE, 1'b1, 32'h0000_0004);
        apb(`IDX_IDLE_CONFIG, 1'b1, 32'h0000_03EF);
        i_cpu.run_idle();
        wait_cy(3);
        check("domain en", 33'(dom_en), 33'h00);
        rd(`IDX_IDLE_STATUS, 33'h0_0000_03E1);
        i_cpu.set_irq(2, 1'b1);
        wait_cy(10);
        check("domain en", 33'(dom_en), 33'h3C);
        rd(`IDX_IDLE_STATUS, 33'h0_0000_0280);
        rd(`IDX_INT_FLAG, 33'h0_0000_0008);
        i_cpu.set_irq(2, 1'b0);
        apb(`IDX_IDLE_CONFIG, 1'b1, 32'h0000_000E);
        i_cpu.run_idle();
        wait_cy(3);
        rd(`IDX_IDLE_STATUS, 33'h0_0000_0000);
        apb(`IDX_PERIPH_GATE_ONE, 1'b1, 32'h0000_8020);
        wait_cy(6);
        check("sys en", 33'(system_clock_en), 33'h0);
        check("domain en", 33'(dom_en[5]), 33'h0);
        @(posedge pclk);
        wake_pin <= 1'b1;
        wait_cy(8);
        check("sys en", 33'(system_clock_en), 33'h1);
        rd(`IDX_PERIPH_GATE_ONE, 33'h0_0000_0020);
        @(posedge pclk);
        wake_pin <= 1'b0;
        wait_cy(2);
        check("reads left", 33'(expq.size()), 33'h0);
        finish_test();
    end
endmodule
